// ### hw/pcr_pkg.sv
// Constants for the capacitance and class readback register bank
package pcr_pkg;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int CH_NUM = 4;
  // Command codes
  localparam logic [7:0] CMD_CH2_CAP = 8'h49;
  localparam logic [7:0] CMD_CH3_CAP = 8'h4a;
  localparam logic [7:0] CMD_CH4_CAP = 8'h4b;
  localparam logic [7:0] CMD_CH1_CLASS = 8'h4c;
  localparam logic [7:0] CMD_CH2_CLASS = 8'h4d;
  localparam logic [7:0] CMD_CH3_CLASS = 8'h4e;
  localparam logic [7:0] CMD_CH4_CLASS = 8'h4f;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  // Capacitance step in nanofarads and usable range in microfarads
  localparam int CAP_STEP_NF = 50;
  localparam int CAP_MIN_UF = 1;
  localparam int CAP_MAX_UF = 12;
  // Class codes
  localparam logic [3:0] CLS_UNKNOWN = 4'h0;
  localparam logic [3:0] CLS_1 = 4'h1;
  localparam logic [3:0] CLS_3 = 4'h3;
  localparam logic [3:0] CLS_4 = 4'h4;
  localparam logic [3:0] CLS_0_PREV = 4'h6;
  localparam logic [3:0] CLS_5_SS = 4'h8;
  localparam logic [3:0] CLS_8_SS = 4'hb;
  localparam logic [3:0] CLS_5_DS = 4'hd;
  // Field positions in a class register
  localparam int GRANT_LSB = 4;
  localparam int EARLIER_LSB = 0;
endpackage : pcr_pkg

// ### hw/pcr_class_chan.sv
// One channel of capacitance and class result storage
`timescale 1ns/10ps
module pcr_class_chan (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Results from the measurement engines
  input wire logic i_cap_valid,
  input wire logic [7:0] i_cap_count,
  input wire logic i_grant_valid,
  input wire logic [3:0] i_grant_class,
  input wire logic i_grant_was_class0,
  input wire logic i_earlier_valid,
  input wire logic [3:0] i_earlier_class,
  input wire logic i_earlier_is_class0,
  input wire logic i_semi_auto,
  input wire logic i_signature_probe_enable,
  input wire logic i_class_enable,
  input wire logic i_turn_off,
  // Stored values
  output logic [7:0] o_cap_count,
  output logic [7:0] o_class_report
);
  logic [3:0] granted_class_nibble;
  logic [3:0] earlier_class_nibble;
  logic [3:0] grant_code;
  logic [3:0] earlier_code;
  logic grant_legal;
  logic earlier_legal;
  logic earlier_allowed;

  // Class 0 at discovery is granted as class 3
  assign grant_code = i_grant_was_class0 ? pcr_pkg::CLS_3 : i_grant_class;
  // Reserved codes never reach the register
  assign grant_legal = (grant_code <= pcr_pkg::CLS_4) ||
    ((grant_code >= pcr_pkg::CLS_5_SS) && (grant_code <= pcr_pkg::CLS_8_SS)) ||
    (grant_code == pcr_pkg::CLS_5_DS);
  assign earlier_code = i_earlier_is_class0 ? pcr_pkg::CLS_0_PREV
    : i_earlier_class;
  assign earlier_legal = (earlier_code <= pcr_pkg::CLS_4) ||
    (earlier_code == pcr_pkg::CLS_0_PREV) ||
    ((earlier_code >= pcr_pkg::CLS_5_SS) &&
     (earlier_code <= pcr_pkg::CLS_8_SS)) ||
    (earlier_code == pcr_pkg::CLS_5_DS);
  // Only semi-auto with ongoing discovery gives a meaningful earlier class
  assign earlier_allowed = i_semi_auto && i_signature_probe_enable &&
    i_class_enable;

  // Turn-off does not touch the count; only a new result or a system reset replaces it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_cap_count <= pcr_pkg::RESET_VALUE;
    end else if (i_cap_valid) begin
      o_cap_count <= i_cap_count;
    end
  end

  // Turn-off wins over a result arriving in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || i_turn_off) begin
      granted_class_nibble <= pcr_pkg::CLS_UNKNOWN;
      earlier_class_nibble <= pcr_pkg::CLS_UNKNOWN;
    end else begin
      if (i_grant_valid && grant_legal) begin
        granted_class_nibble <= grant_code;
      end
      if (i_earlier_valid && earlier_legal && earlier_allowed) begin
        earlier_class_nibble <= earlier_code;
      end
    end
  end

  assign o_class_report = {granted_class_nibble, earlier_class_nibble};
endmodule : pcr_class_chan

// ### hw/pcr_readback.sv
// Capacitance and class readback register bank, command-code read port
// Behaviour
// - Capacitance register holds latest eight-bit count
// - Count times 0.05 uF, one to twelve uF
// - Capacitance kept when channel powers off
// - Channel 3/4 capacitance read-only at 4Ah, 4Bh
// - Class registers 4Ch-4Fh read-only, reset zero
// - Upper nibble granted class, lower earlier class
// - Lower nibble holds previous classification result
// - Turn-off clears both class nibbles
// - Granted class codes; reserved codes never reported
// - Earlier codes same, 0110 means class 0
// - Class 0 signature reported as class 3
// - Earlier class valid only semi-auto, probe+class enabled
`timescale 1ns/10ps
module pcr_readback #(
  parameter int CH_NUM = pcr_pkg::CH_NUM
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Command read and write port from the serial slave
  input wire logic i_rd_strobe,
  input wire logic i_wr_strobe,
  input wire logic [7:0] i_cmd_code,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_cmd_hit,
  output logic o_wr_refused,
  // Measurement results, one bit or slice per channel (index 0 = channel 1)
  input wire logic [CH_NUM-1:0] i_cap_valid,
  input wire logic [CH_NUM*8-1:0] i_cap_count,
  input wire logic [CH_NUM-1:0] i_grant_valid,
  input wire logic [CH_NUM*4-1:0] i_grant_class,
  input wire logic [CH_NUM-1:0] i_grant_was_class0,
  input wire logic [CH_NUM-1:0] i_earlier_valid,
  input wire logic [CH_NUM*4-1:0] i_earlier_class,
  input wire logic [CH_NUM-1:0] i_earlier_is_class0,
  // Channel mode and enables
  input wire logic [CH_NUM-1:0] i_semi_auto,
  input wire logic [CH_NUM-1:0] i_signature_probe_enable,
  input wire logic [CH_NUM-1:0] i_class_enable,
  input wire logic [CH_NUM-1:0] i_turn_off
);
  logic [CH_NUM*8-1:0] cap_regs;
  logic [CH_NUM*8-1:0] class_regs;
  logic [7:0] next_rd_data;
  logic hit_cap;
  logic hit_class;

  // Count is stored raw; the step of CAP_STEP_NF is applied by software
  genvar g;
  generate
    for (g = 0; g < CH_NUM; g = g + 1) begin : g_chan
      pcr_class_chan u_chan (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_cap_valid(i_cap_valid[g]),
        .i_cap_count(i_cap_count[g*8 +: 8]),
        .i_grant_valid(i_grant_valid[g]),
        .i_grant_class(i_grant_class[g*4 +: 4]),
        .i_grant_was_class0(i_grant_was_class0[g]),
        .i_earlier_valid(i_earlier_valid[g]),
        .i_earlier_class(i_earlier_class[g*4 +: 4]),
        .i_earlier_is_class0(i_earlier_is_class0[g]),
        .i_semi_auto(i_semi_auto[g]),
        .i_signature_probe_enable(i_signature_probe_enable[g]),
        .i_class_enable(i_class_enable[g]),
        .i_turn_off(i_turn_off[g]),
        .o_cap_count(cap_regs[g*8 +: 8]),
        .o_class_report(class_regs[g*8 +: 8])
      );
    end
  endgenerate

  assign hit_cap = (i_cmd_code == pcr_pkg::CMD_CH2_CAP) ||
    (i_cmd_code == pcr_pkg::CMD_CH3_CAP) ||
    (i_cmd_code == pcr_pkg::CMD_CH4_CAP);
  assign hit_class = (i_cmd_code >= pcr_pkg::CMD_CH1_CLASS) &&
    (i_cmd_code <= pcr_pkg::CMD_CH4_CLASS);

  // Pure read mux: nothing in the bank changes on a read
  always_comb begin
    if (i_cmd_code == pcr_pkg::CMD_CH2_CAP) begin
      next_rd_data = cap_regs[15:8];
    end else if (i_cmd_code == pcr_pkg::CMD_CH3_CAP) begin
      next_rd_data = cap_regs[23:16];
    end else if (i_cmd_code == pcr_pkg::CMD_CH4_CAP) begin
      next_rd_data = cap_regs[31:24];
    end else if (i_cmd_code == pcr_pkg::CMD_CH1_CLASS) begin
      next_rd_data = class_regs[7:0];
    end else if (i_cmd_code == pcr_pkg::CMD_CH2_CLASS) begin
      next_rd_data = class_regs[15:8];
    end else if (i_cmd_code == pcr_pkg::CMD_CH3_CLASS) begin
      next_rd_data = class_regs[23:16];
    end else if (i_cmd_code == pcr_pkg::CMD_CH4_CLASS) begin
      next_rd_data = class_regs[31:24];
    end else begin
      next_rd_data = pcr_pkg::UNMAPPED_VALUE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rd_data <= pcr_pkg::RESET_VALUE;
      o_rd_valid <= 1'b0;
      o_cmd_hit <= 1'b0;
      o_wr_refused <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_strobe;
      o_cmd_hit <= (i_rd_strobe || i_wr_strobe) && (hit_cap || hit_class);
      // Writes are dropped; the data byte is ignored
      o_wr_refused <= i_wr_strobe && (hit_cap || hit_class);
      if (i_rd_strobe) begin
        o_rd_data <= next_rd_data;
      end
    end
  end
endmodule : pcr_readback

// ### testbench/pcr_readback_chk.sv
// Assertions on the readback port
`timescale 1ns/10ps
module pcr_readback_chk #(parameter int CH_NUM = 4) (
  input wire logic i_clock, i_sys_rst, i_rd_strobe, i_wr_strobe,
  input wire logic [7:0] i_cmd_code, o_rd_data,
  input wire logic o_rd_valid, o_cmd_hit, o_wr_refused,
  input wire logic [CH_NUM-1:0] i_cap_valid, i_grant_valid, i_turn_off,
  input wire logic [CH_NUM-1:0] i_grant_was_class0,
  input wire logic [CH_NUM*8-1:0] i_cap_count
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire logic mapped = i_cmd_code >= 8'h49 && i_cmd_code <= 8'h4f;
  a_valid_timing: assert property (o_rd_valid == $past(i_rd_strobe))
    else $error("late read valid");
  a_hit_mapped: assert property (
    i_rd_strobe |=> o_cmd_hit == $past(mapped))
    else $error("bad hit");
  a_unmapped_zero: assert property (
    i_rd_strobe && !mapped |=> !o_rd_data)
    else $error("unmapped not zero");
  a_wr_refused: assert property (
    o_wr_refused == $past(i_wr_strobe && mapped))
    else $error("bad refusal");
  a_data_held: assert property (!i_rd_strobe |=> $stable(o_rd_data))
    else $error("data moved");
  a_cap_latest: assert property (i_cap_valid[2] ##1 i_rd_strobe &&
    i_cmd_code == 8'h4a |=> o_rd_data == $past(i_cap_count[23:16], 2))
    else $error("stale count");
  a_off_clears: assert property (i_turn_off[0] ##1 i_rd_strobe &&
    i_cmd_code == 8'h4c && !i_grant_valid[0] |=> o_rd_data == 8'h00)
    else $error("class kept");
  a_class0_three: assert property (
    i_grant_valid[0] && i_grant_was_class0[0] && !i_turn_off[0]
    ##1 i_rd_strobe && i_cmd_code == 8'h4c |=> o_rd_data[7:4] == 4'h3)
    else $error("class 0 grant");
endmodule : pcr_readback_chk
bind pcr_readback pcr_readback_chk #(.CH_NUM(CH_NUM)) u_chk (.i_clock,
  .i_sys_rst, .i_rd_strobe, .i_wr_strobe, .i_cmd_code, .o_rd_data, .o_rd_valid,
  .o_cmd_hit, .o_wr_refused, .i_cap_valid, .i_grant_valid, .i_turn_off,
  .i_grant_was_class0, .i_cap_count);

// ### testbench/pcr_host.sv
// Host model issuing single-byte command transfers
`timescale 1ns/10ps
module pcr_host (
  input wire logic i_clock,
  output logic o_rd = 1'b0,
  output logic o_wr = 1'b0,
  output logic [7:0] o_cmd = 8'h00,
  output logic [7:0] o_wdata = 8'h00
);
  // Idle cycles roam the code so a stale code is never a live request
  task automatic req(input logic rd, wr, input logic [7:0] c);
    o_rd <= rd;
    o_wr <= wr;
    o_cmd <= (rd | wr) ? c : 8'($urandom);
    o_wdata <= 8'($urandom);
    @(posedge i_clock);
  endtask : req
endmodule : pcr_host

// ### testbench/tb.sv
// Self-checking bench for the readback register bank
`timescale 1ns/10ps
module tb;
  logic i_clock = 1'b0, i_sys_rst = 1'b1, rd, wr, vld, hit, wref;
  logic [3:0] cv = '0, gv = '0, g0 = '0, ev = '0, e0 = '0, off = '0;
  logic [3:0] sa = '1, pe = '1, ce = '1;
  logic [31:0] cc = '0;
  logic [15:0] gc = '0, ec = '0;
  logic [7:0] cmd, wd, dat;
  logic [8:0] exp_q[$], e;
  logic [7:0] cls[4] = '{default: 8'h00};
  int failures = 0, samples_checked = 0;
  int w_due = 0;
  always #5 i_clock = ~i_clock;
  pcr_host u_host (.i_clock, .o_rd(rd), .o_wr(wr), .o_cmd(cmd), .o_wdata(wd));
  pcr_readback DUT (.i_clock, .i_sys_rst, .i_rd_strobe(rd), .i_wr_strobe(wr),
    .i_cmd_code(cmd), .i_wr_data(wd), .o_rd_data(dat), .o_rd_valid(vld),
    .o_cmd_hit(hit), .o_wr_refused(wref), .i_cap_valid(cv), .i_cap_count(cc),
    .i_grant_valid(gv), .i_grant_class(gc), .i_grant_was_class0(g0),
    .i_earlier_valid(ev), .i_earlier_class(ec), .i_earlier_is_class0(e0),
    .i_semi_auto(sa), .i_signature_probe_enable(pe), .i_class_enable(ce),
    .i_turn_off(off));
  always @(posedge i_clock) if (vld === 1'b1) begin
    e = exp_q.pop_front();
    samples_checked++;
    if ({hit, dat} !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, {hit, dat}, e);
    end
  end
  // Every refused write must match one mapped write that the bench issued
  always @(posedge i_clock) if (wref === 1'b1) begin
    samples_checked++;
    if (w_due == 0 || hit !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: stray write refusal", $time);
    end
    w_due--;
  end
  task automatic rd_exp(input logic [7:0] c, d);
    exp_q.push_back({c >= 8'h49 && c <= 8'h4f, d});
    u_host.req(1'b1, 1'b0, c);
  endtask : rd_exp
  task automatic cls_put(input int k, input logic [3:0] g, p);
    gc[k*4+:4] <= g;
    ec[k*4+:4] <= p;
    {gv[k], ev[k]} <= 2'b11;
    // Idle request lowers a read strobe left standing by the last read
    u_host.req(1'b0, 1'b0, 8'h00);
    {gv[k], ev[k]} <= 2'b00;
  endtask : cls_put
  task automatic wrap_up();
    if (exp_q.size() != 0 || w_due != 0) failures++;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
  initial begin
    void'($urandom(31));
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    // Back to back reads of every code around the bank
    for (int c = 'h48; c <= 'h50; c++) rd_exp(8'(c), 8'h00);
    for (int k = 1; k < 4; k++) begin
      // Counts stay within the usable 1 to 12 uF span
      cc[k*8+:8] <= 8'(20 + $urandom % 221);
      cv[k] <= 1'b1;
      u_host.req(1'b0, 1'b0, 8'h00);
      cv[k] <= 1'b0;
      rd_exp(8'h48 + 8'(k), cc[k*8+:8]);
      off[k] <= 1'b1;
      w_due++;
      u_host.req(1'b0, 1'b1, 8'h48 + 8'(k));
      off[k] <= 1'b0;
      rd_exp(8'h48 + 8'(k), cc[k*8+:8]);
    end
    for (int i = 0; i < 16; i++) begin
      if (i == 6) continue;
      cls_put(i % 4, 4'(i), 4'(i));
      if (i inside {[0:4], [8:11], 13}) cls[i%4] = 8'(i * 17);
      rd_exp(8'h4c + 8'(i % 4), cls[i%4]);
    end
    {g0[0], e0[0]} <= 2'b11;
    cls_put(0, 4'h1, 4'h1);
    {g0[0], e0[0]} <= 2'b00;
    rd_exp(8'h4c, 8'h36);
    {sa[0], pe[0], ce[0]} <= 3'b111 ^ (3'b001 << ($urandom % 3));
    cls_put(0, 4'h4, 4'h2);
    rd_exp(8'h4c, 8'h46);
    off[0] <= 1'b1;
    u_host.req(1'b0, 1'b0, 8'h00);
    rd_exp(8'h4c, 8'h00);
    off <= '0;
    repeat (2) u_host.req(1'b0, 1'b0, 8'h00);
    wrap_up();
  end
endmodule : tb
